// *** hdl/cell_extract_pkg.sv ***
// Package with register map, field positions, reset values and carrier types for cell extraction.
package cell_extract_pkg;

    // Register offsets within the low address byte of the processor interface.
    localparam logic [7:0] OFS_INT_STATUS = 8'h0B;
    localparam logic [7:0] OFS_INT_ENABLE = 8'h0F;
    localparam logic [7:0] OFS_MEM_CTRL = 8'h13;
    localparam logic [7:0] OFS_DATA_B3 = 8'h14;
    localparam logic [7:0] OFS_DATA_B2 = 8'h15;
    localparam logic [7:0] OFS_DATA_B1 = 8'h16;
    localparam logic [7:0] OFS_DATA_B0 = 8'h17;

    // Field positions within cell_memory_control.
    localparam int CTRL_INS_SOC = 0;
    localparam int CTRL_INS_ROOM = 1;
    localparam int CTRL_INS_RESET_N = 2;
    localparam int CTRL_EXT_WAITING = 3;
    localparam int CTRL_EXT_RESET_N = 4;

    // Field position of the extraction event in the status and enable registers.
    localparam int INT_EXTRACT_BIT = 5;

    // Reset values of the processor registers and the interrupt enable write mask.
    localparam logic [7:0] CTRL_RESET = 8'h16;
    localparam logic [7:0] INT_ENABLE_RESET = 8'h00;
    localparam logic [7:0] INT_STATUS_RESET = 8'h00;
    localparam logic [7:0] INT_ENABLE_MASK = 8'h3F;

    // Cell geometry: words per cell and bytes per word.
    localparam int CELL_WORDS = 14;
    localparam int WORD_BYTES = 4;
    localparam int CELL_BYTES = 56;

    // One processor access as seen on the pins.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } up_req_t;

    // One 32-bit word of a copied cell from the user cell filter.
    typedef struct packed {
        logic first;
        logic [31:0] data;
    } cell_word_t;

endpackage

// *** hdl/cell_word_fifo.sv ***
// Word FIFO with registered head data that buffers copied cells.
`timescale 1ns/10ps
`default_nettype none
module cell_word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clear,
    input wire logic in_valid,
    output var logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output var logic out_valid,
    input wire logic out_ready,
    output var logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // Refuse shapes that the pointer arithmetic cannot serve.
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("cell_word_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];  // Word storage.
    logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;  // Next slot to fill.
    logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;  // Slot of the head word.
    logic [AW:0] count_ff, nxt_count;  // Words held.
    logic in_ready_ff, nxt_in_ready;  // Registered space flag.
    logic [WIDTH-1:0] head_ff, nxt_head;  // Registered head word.
    logic push;
    logic pop;

    // Next pointers, count, space flag and head word.
    always_comb begin
        push = in_valid && in_ready_ff && !clear;
        pop = out_ready && (count_ff != '0) && !clear;
        nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
        nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
        nxt_count = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        if (clear) begin
            // A flush drops everything held.
            nxt_wr_ptr = '0;
            nxt_rd_ptr = '0;
            nxt_count = '0;
        end
        // Space is refused during a flush so no word slips in.
        nxt_in_ready = !clear && (nxt_count < (AW + 1)'(DEPTH));
        // The head follows the slot it will point at; bypass a word landing there now.
        if (push && (wr_ptr_ff == nxt_rd_ptr)) begin
            nxt_head = in_data;
        end else begin
            nxt_head = mem_ff[nxt_rd_ptr];
        end
    end

    // Registers of the FIFO; storage has no reset.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
            in_ready_ff <= 1'b0;
            head_ff <= '0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff <= nxt_count;
            in_ready_ff <= nxt_in_ready;
            head_ff <= nxt_head;
        end
    end

    // Storage write port.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    assign in_ready = in_ready_ff;
    assign out_valid = (count_ff != '0);
    assign out_data = head_ff;
endmodule
`default_nettype wire

// *** hdl/tx_cell_extraction_buffer.sv ***
// Transmit cell extraction buffer with its byte-wide processor registers.
//
// Operation
// - Data register reads return extraction buffer contents.
// - Filter copies matching cells into this buffer.
// - Cells are 56 bytes, read as words.
// - Control bit 4 low flushes the buffer.
// - Control bit 3 shows a waiting cell.
// - Enabled interrupt fires on each loaded cell.
// - Loaded cell sets status bit 5, interrupt low.
// - First cell byte sits in byte-3 register.
//
// Notes
// The processor pins are asynchronous and pass two flip-flops before use,
// so an access is taken one clock after its strobe is first sampled high
// and a read is answered one clock later.
// Writes to the shared data registers belong to the insertion side and are
// ignored here; reads of them always come from the extraction buffer.
// A cell counts as waiting only once all of its words have entered.
// The word counters hold at most fifteen words per cell.
`timescale 1ns/10ps
`default_nettype none
module tx_cell_extraction_buffer
    import cell_extract_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int WORDS_PER_CELL = CELL_WORDS
) (
    input wire logic clk,
    input wire logic resetn,
    // Processor pins: address, write data, read and write strobes.
    input wire up_req_t up_req,
    output var logic [7:0] up_rdata,
    output var logic up_rd_ack,
    // Copied cell words from the user cell filter.
    input wire cell_word_t cell_in,
    input wire logic cell_in_valid,
    output var logic cell_in_ready,
    // Insertion side controls held in the shared control register.
    output var logic insert_soc,
    output var logic insert_reset_n,
    // Interrupt pin, active low.
    output var logic int_n
);
    // The word counters are four bits wide, which caps the cell length.
    // Refuse a buffer that cannot hold a whole cell.
    if (DEPTH < WORDS_PER_CELL || WORDS_PER_CELL < 1 || WORDS_PER_CELL > 15) begin : g_bad_cfg
        $error("extraction buffer must hold one cell of 1 to 15 words");
    end

    // Position of the final word of a cell; both word counters wrap after it.
    localparam logic [3:0] LAST_WORD = 4'(WORDS_PER_CELL - 1);

    // Two-stage synchroniser for the processor pins plus a third stage for edges.
    // Address and data are held steady around the strobe, so their bits settle together.
    up_req_t req_meta_ff, nxt_req_meta;  // First stage, read only by the second.
    up_req_t req_sync_ff, nxt_req_sync;  // Second stage, safe to use.
    logic rd_dly_ff, nxt_rd_dly;  // Delayed read strobe for edge detection.
    logic wr_dly_ff, nxt_wr_dly;  // Delayed write strobe for edge detection.
    logic rd_pulse;  // One-cycle read access.
    logic wr_pulse;  // One-cycle write access.

    // Processor registers.
    logic [7:0] ctrl_ff, nxt_ctrl;  // cell_memory_control, stored bits.
    logic [7:0] int_en_ff, nxt_int_en;  // Interrupt enable register.
    logic [7:0] int_st_ff, nxt_int_st;  // Interrupt status register.
    logic [7:0] rdata_ff, nxt_rdata;  // Registered read data.
    logic rd_ack_ff, nxt_rd_ack;  // Read answer pulse.
    logic int_n_ff, nxt_int_n;  // Registered interrupt pin.

    // Counters are sized for the fifteen-word limit refused above.
    // Cell accounting.
    logic [3:0] in_idx_ff, nxt_in_idx;  // Word position of the next incoming word.
    logic [3:0] out_idx_ff, nxt_out_idx;  // Word position of the next word read out.
    logic [4:0] cells_ff, nxt_cells;  // Complete cells held.
    logic [31:0] word_ff, nxt_word;  // Word latched by the byte-3 read.

    // FIFO hookup.
    logic flush;  // Active while the extraction reset bit is low.
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [31:0] fifo_out_data;
    // Strobes of the buffer and of the cell bookkeeping.
    logic push;  // A cell word enters the buffer.
    logic pop;  // The processor takes the head word.
    logic cell_loaded;  // The last word of a cell enters.
    logic cell_drained;  // The last word of a cell leaves.

    // Address decode helper used by the read path only.
    // Byte 0 is the data offset left over once bytes 3 to 1 are ruled out.
    function automatic logic is_data_reg(input logic [7:0] addr);
        is_data_reg = (addr == OFS_DATA_B3) || (addr == OFS_DATA_B2) ||
            (addr == OFS_DATA_B1) || (addr == OFS_DATA_B0);
    endfunction

    // Synchroniser next values.
    // A strobe counts once, on its rising edge as seen after the second stage.
    // The delayed copies reset low, the idle level of the strobes, so no false edge follows reset.
    always_comb begin
        nxt_req_meta = up_req;
        nxt_req_sync = req_meta_ff;
        nxt_rd_dly = req_sync_ff.rd;
        nxt_wr_dly = req_sync_ff.wr;
        rd_pulse = req_sync_ff.rd && !rd_dly_ff;
        wr_pulse = req_sync_ff.wr && !wr_dly_ff;
    end

    // Synchroniser registers.
    // All stages clear on reset, so a strobe held through reset is seen as a new access.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            req_meta_ff <= '0;
            req_sync_ff <= '0;
            rd_dly_ff <= 1'b0;
            wr_dly_ff <= 1'b0;
        end else begin
            req_meta_ff <= nxt_req_meta;
            req_sync_ff <= nxt_req_sync;
            rd_dly_ff <= nxt_rd_dly;
            wr_dly_ff <= nxt_wr_dly;
        end
    end

    // Buffer flush follows the active-low reset bit in the control register.
    // From the clock after the bit goes low the buffer is held empty and the filter sees no space.
    // Flushing leaves the sticky status bit alone, so a pending event is not lost.
    assign flush = !ctrl_ff[CTRL_EXT_RESET_N];

    // Copied cells enter the buffer with back-pressure toward the filter.
    // Sixteen words hold one whole cell with some slack, so the filter can start
    // the next cell while the processor is still reading the previous one.
    cell_word_fifo #(
        .WIDTH(32),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .clear(flush),
        .in_valid(cell_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(cell_in.data),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data)
    );

    // Cell accounting next values.
    always_comb begin
        // The filter sees ready from the FIFO; a word offered in the first flush cycle sees it
        // still high and is dropped, while later ones wait, since the FIFO refuses them as well.
        push = cell_in_valid && fifo_in_ready && !flush;
        // A byte-3 read takes one word from the extraction side only.
        // The other three bytes replay the latched word, so reading them twice
        // does no harm.
        pop = rd_pulse && (req_sync_ff.addr == OFS_DATA_B3) && fifo_out_valid;
        nxt_in_idx = in_idx_ff;
        nxt_out_idx = out_idx_ff;
        cell_loaded = 1'b0;
        cell_drained = 1'b0;
        // Write-side positions count the words of the cell now entering.
        if (push) begin
            // A first-word mark realigns the word count to a cell boundary.
            if (cell_in.first) begin
                nxt_in_idx = 4'h1;
            end else if (in_idx_ff == LAST_WORD) begin
                nxt_in_idx = 4'h0;
            end else begin
                nxt_in_idx = in_idx_ff + 4'h1;
            end
            // The fourteenth word completes a 56-byte cell.
            cell_loaded = cell_in.first ? (LAST_WORD == 4'h0) : (in_idx_ff == LAST_WORD);
        end
        // Read-side positions follow the processor's byte-3 reads.
        if (pop) begin
            // Fourteen word reads drain one cell.
            if (out_idx_ff == LAST_WORD) begin
                nxt_out_idx = 4'h0;
                cell_drained = 1'b1;
            end else begin
                nxt_out_idx = out_idx_ff + 4'h1;
            end
        end
        // A drained cell counts down only when one is held, so the count never wraps.
        nxt_cells = cells_ff + {4'h0, cell_loaded} - {4'h0, cell_drained && (cells_ff != 5'h00)};
        // The word read by byte 3 is held for the byte-2, byte-1 and byte-0 reads.
        nxt_word = pop ? fifo_out_data : word_ff;
        // A flush restarts both word counters at a cell boundary.
        if (flush) begin
            nxt_in_idx = 4'h0;
            nxt_out_idx = 4'h0;
            nxt_cells = 5'h00;
            nxt_word = 32'h0000_0000;
        end
    end

    // Cell accounting registers.
    // They share the flush with the FIFO, so both sides agree on empty.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            in_idx_ff <= 4'h0;
            out_idx_ff <= 4'h0;
            cells_ff <= 5'h00;
            word_ff <= 32'h0000_0000;
        end else begin
            in_idx_ff <= nxt_in_idx;
            out_idx_ff <= nxt_out_idx;
            cells_ff <= nxt_cells;
            word_ff <= nxt_word;
        end
    end

    // Register writes, read data, status and interrupt next values.
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_int_en = int_en_ff;
        nxt_int_st = int_st_ff;
        nxt_rdata = rdata_ff;
        nxt_rd_ack = rd_pulse;
        // Writes: control and enable are stored, data writes belong to insertion.
        if (wr_pulse) begin
            if (req_sync_ff.addr == OFS_MEM_CTRL) begin
                nxt_ctrl[CTRL_EXT_RESET_N] = req_sync_ff.wdata[CTRL_EXT_RESET_N];
                nxt_ctrl[CTRL_INS_RESET_N] = req_sync_ff.wdata[CTRL_INS_RESET_N];
                nxt_ctrl[CTRL_INS_ROOM] = req_sync_ff.wdata[CTRL_INS_ROOM];
                nxt_ctrl[CTRL_INS_SOC] = req_sync_ff.wdata[CTRL_INS_SOC];
            end else if (req_sync_ff.addr == OFS_INT_ENABLE) begin
                nxt_int_en = req_sync_ff.wdata & INT_ENABLE_MASK;
            end
            // Other offsets, the data bytes and the status register among them, ignore writes.
        end
        // Reads: the status register clears when read.
        // The answer is registered one clock after the pulse, together with its data.
        if (rd_pulse) begin
            if (req_sync_ff.addr == OFS_MEM_CTRL) begin
                nxt_rdata = ctrl_ff;
                // The waiting bit reports a complete cell in the buffer.
                nxt_rdata[CTRL_EXT_WAITING] = (cells_ff != 5'h00);
                // The unused top bits read as zero whatever was written.
                nxt_rdata[7:5] = 3'h0;
            end else if (req_sync_ff.addr == OFS_INT_ENABLE) begin
                nxt_rdata = int_en_ff;
            end else if (req_sync_ff.addr == OFS_INT_STATUS) begin
                nxt_rdata = int_st_ff;
                nxt_int_st = INT_STATUS_RESET;
            end else if (req_sync_ff.addr == OFS_DATA_B3) begin
                // An empty buffer answers zero and takes nothing.
                nxt_rdata = fifo_out_valid ? fifo_out_data[31:24] : 8'h00;
            end else if (req_sync_ff.addr == OFS_DATA_B2) begin
                nxt_rdata = word_ff[23:16];
            end else if (req_sync_ff.addr == OFS_DATA_B1) begin
                nxt_rdata = word_ff[15:8];
            end else if (is_data_reg(req_sync_ff.addr)) begin
                nxt_rdata = word_ff[7:0];
            end else begin
                // Unmapped offsets read as zero.
                nxt_rdata = 8'h00;
            end
        end
        // A loaded cell sets the sticky status bit; the set wins over a read-clear.
        if (cell_loaded && !flush) begin
            nxt_int_st[INT_EXTRACT_BIT] = 1'b1;
        end
        // The interrupt pin is low while an enabled status bit is set.
        // Both next values feed the pin, so it follows a write of the enable at once.
        nxt_int_n = !(|(nxt_int_st & nxt_int_en));
    end

    // Processor register bank.
    // The interrupt pin resets high, so no request is seen while the block wakes.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_ff <= CTRL_RESET;
            int_en_ff <= INT_ENABLE_RESET;
            int_st_ff <= INT_STATUS_RESET;
            rdata_ff <= 8'h00;
            rd_ack_ff <= 1'b0;
            int_n_ff <= 1'b1;
        end else begin
            ctrl_ff <= nxt_ctrl;
            int_en_ff <= nxt_int_en;
            int_st_ff <= nxt_int_st;
            rdata_ff <= nxt_rdata;
            rd_ack_ff <= nxt_rd_ack;
            int_n_ff <= nxt_int_n;
        end
    end

    // Outputs come straight from flip-flops.
    // The ready flag is the FIFO's own register, so it too leaves a flip-flop.
    assign up_rdata = rdata_ff;
    assign up_rd_ack = rd_ack_ff;
    assign cell_in_ready = fifo_in_ready;
    assign insert_soc = ctrl_ff[CTRL_INS_SOC];
    assign insert_reset_n = ctrl_ff[CTRL_INS_RESET_N];
    assign int_n = int_n_ff;
endmodule
`default_nettype wire

// *** bench/extract_monitor.sv ***
// Concurrent checks on the pins of the cell extraction buffer.
`timescale 1ns/10ps
`default_nettype none
module extract_monitor
    import cell_extract_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire up_req_t up_req,
    input wire logic [7:0] up_rdata,
    input wire logic up_rd_ack,
    input wire cell_word_t cell_in,
    input wire logic cell_in_valid,
    input wire logic cell_in_ready,
    input wire logic insert_soc,
    input wire logic insert_reset_n,
    input wire logic int_n
);
    // All checks share one clock and sleep while reset is applied.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    reset_state_a: assert property ($rose(resetn) |-> int_n && !up_rd_ack &&
        !insert_soc && insert_reset_n ##1 cell_in_ready) else $error("bad reset state");
    ack_pulse_a: assert property (up_rd_ack |=> !up_rd_ack)
        else $error("read acknowledge too long");
    ack_cause_a: assert property (up_rd_ack |-> $past(up_req.rd, 3))
        else $error("acknowledge without a read");
    rd_answer_a: assert property ($rose(up_req.rd) |-> ##[3:5] up_rd_ack)
        else $error("read not answered");
    rdata_hold_a: assert property ($changed(up_rdata) |-> up_rd_ack)
        else $error("read data moved without a read");
    int_cause_a: assert property ($fell(int_n) |-> $past(cell_in_valid && cell_in_ready, 1)
        || $past(cell_in_valid && cell_in_ready, 2)) else $error("interrupt without a cell");
    int_clear_a: assert property ($rose(int_n) |-> $past(up_req.rd, 3)
        || $past(up_req.wr, 3)) else $error("interrupt released without access");
    ctrl_write_a: assert property ($changed(insert_soc) |-> $past(up_req.wr, 3)
        && $past(up_req.addr, 3) == OFS_MEM_CTRL) else $error("start bit moved unasked");
endmodule
bind tx_cell_extraction_buffer extract_monitor i_mon (
    .clk(clk), .resetn(resetn), .up_req(up_req), .up_rdata(up_rdata),
    .up_rd_ack(up_rd_ack), .cell_in(cell_in), .cell_in_valid(cell_in_valid),
    .cell_in_ready(cell_in_ready), .insert_soc(insert_soc),
    .insert_reset_n(insert_reset_n), .int_n(int_n)
);
`default_nettype wire

// *** bench/up_cpu_model.sv ***
// Processor model that makes byte register accesses on the block's pins.
`timescale 1ns/10ps
`default_nettype none
module up_cpu_model
    import cell_extract_pkg::*;
(
    input wire logic clk,
    output var up_req_t up_req,
    input wire logic [7:0] up_rdata,
    input wire logic up_rd_ack
);
    // Strobes start low so nothing is requested before reset ends.
    initial begin
        up_req = '0;
    end
    // Address and data settle two edges ahead of the strobe.
    task automatic setup(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        up_req.addr <= a;
        up_req.wdata <= d;
        repeat (2) @(posedge clk);
    endtask
    // The write strobe stands four edges, then rests three.
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        setup(a, d);
        up_req.wr <= 1'b1;
        repeat (4) @(posedge clk);
        up_req.wr <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // The read strobe stands until the acknowledge is sampled high.
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        int n;
        setup(a, ~up_req.wdata);
        up_req.rd <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (up_rd_ack !== 1'b1 && n < 20);
        d = (n < 20) ? up_rdata : 8'hxx;
        up_req.rd <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // Polls the waiting bit and gives up after a bounded count.
    task automatic wait_cell(output logic ok);
        logic [7:0] v;
        ok = 1'b0;
        for (int i = 0; i < 20 && !ok; i++) begin
            reg_read(OFS_MEM_CTRL, v);
            ok = (v[CTRL_EXT_WAITING] === 1'b1);
        end
    endtask
endmodule
`default_nettype wire

// *** bench/tb_tx_cell_extraction_buffer.sv ***
// Self-checking testbench for the cell extraction buffer.
`timescale 1ns/10ps
`default_nettype none
module tb_tx_cell_extraction_buffer
    import cell_extract_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    cell_word_t cell_in = '0;
    logic cell_in_valid = 1'b0;
    up_req_t up_req;
    logic [7:0] up_rdata;
    logic up_rd_ack, cell_in_ready, insert_soc, insert_reset_n, int_n, ok;
    int failures = 0;
    int checks = 0;

    always #25 clk = ~clk;

    tx_cell_extraction_buffer i_dut (.clk(clk), .resetn(resetn), .up_req(up_req),
        .up_rdata(up_rdata), .up_rd_ack(up_rd_ack), .cell_in(cell_in),
        .cell_in_valid(cell_in_valid), .cell_in_ready(cell_in_ready),
        .insert_soc(insert_soc), .insert_reset_n(insert_reset_n), .int_n(int_n));
    up_cpu_model i_cpu (.clk(clk), .up_req(up_req), .up_rdata(up_rdata),
        .up_rd_ack(up_rd_ack));

    // Word pattern: top byte never zero, so an empty read stands out.
    function automatic logic [31:0] wv(input int c, input int w);
        return {4'hC, c[3:0], 8'(w), ~8'(w), 8'(c)};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_cpu.reg_read(a, d);
        check(32'(d), 32'(exp));
    endtask
    // Offers words of one cell; the caller drops valid after the last.
    task automatic push(input int c, input int n);
        int t;
        for (int w = 0; w < n; w++) begin
            cell_in <= {w == 0, wv(c, w)};
            cell_in_valid <= 1'b1;
            t = 0;
            do begin
                @(posedge clk);
                t++;
            end while (cell_in_ready !== 1'b1 && t < 50);
        end
    endtask
    // Reads words byte 3 first and rebuilds them.
    task automatic read_cell(input int c, input int n);
        logic [7:0] b3, b2, b1, b0;
        for (int w = 0; w < n; w++) begin
            i_cpu.reg_read(OFS_DATA_B3, b3);
            i_cpu.reg_read(OFS_DATA_B2, b2);
            i_cpu.reg_read(OFS_DATA_B1, b1);
            i_cpu.reg_read(OFS_DATA_B0, b0);
            check({b3, b2, b1, b0}, wv(c, w));
        end
    endtask
    task automatic t_reset();
        rd(OFS_MEM_CTRL, CTRL_RESET);
        rd(OFS_INT_ENABLE, INT_ENABLE_RESET);
        rd(OFS_INT_STATUS, INT_STATUS_RESET);
        rd(8'h00, 8'h00);
        i_cpu.reg_write(OFS_MEM_CTRL, 8'h17);
        check(32'(insert_soc), 32'h0000_0001);
        i_cpu.reg_write(OFS_MEM_CTRL, 8'h12);
        check(32'(insert_reset_n), 32'h0000_0000);
        i_cpu.reg_write(OFS_MEM_CTRL, 8'h06);
        i_cpu.reg_write(OFS_MEM_CTRL, CTRL_RESET);
        check(32'(insert_soc), 32'h0000_0000);
        check(32'(insert_reset_n), 32'h0000_0001);
        $display("test reset done");
    endtask
    task automatic t_irq();
        i_cpu.reg_write(OFS_INT_ENABLE, 8'h20);
        rd(OFS_INT_ENABLE, 8'h20);
        push(1, CELL_WORDS);
        cell_in_valid <= 1'b0;
        i_cpu.wait_cell(ok);
        check(32'(ok), 32'h0000_0001);
        check(32'(int_n), 32'h0000_0000);
        rd(OFS_INT_STATUS, 8'h20);
        check(32'(int_n), 32'h0000_0001);
        rd(OFS_MEM_CTRL, 8'h1E);
        read_cell(1, CELL_WORDS);
        rd(OFS_MEM_CTRL, CTRL_RESET);
        $display("test interrupt done");
    endtask
    // Fills sixteen words, sees the refusal, then drains to empty.
    task automatic t_fill();
        i_cpu.reg_write(OFS_INT_ENABLE, 8'h00);
        push(2, CELL_WORDS);
        push(3, 2);
        cell_in <= {1'b0, wv(3, 2)};
        repeat (3) @(posedge clk);
        check(32'(cell_in_ready), 32'h0000_0000);
        cell_in_valid <= 1'b0;
        check(32'(int_n), 32'h0000_0001);
        rd(OFS_INT_STATUS, 8'h20);
        read_cell(2, CELL_WORDS);
        rd(OFS_MEM_CTRL, CTRL_RESET);
        read_cell(3, 2);
        rd(OFS_DATA_B3, 8'h00);
        $display("test fill done");
    endtask
    task automatic t_flush();
        push(4, CELL_WORDS);
        cell_in_valid <= 1'b0;
        i_cpu.reg_write(OFS_MEM_CTRL, 8'h06);
        check(32'(cell_in_ready), 32'h0000_0000);
        rd(OFS_MEM_CTRL, 8'h06);
        i_cpu.reg_write(OFS_MEM_CTRL, CTRL_RESET);
        rd(OFS_MEM_CTRL, CTRL_RESET);
        rd(OFS_DATA_B3, 8'h00);
        $display("test flush done");
    endtask
    // A full insertion write sequence lands elsewhere and leaves extraction data intact.
    task automatic t_insert();
        push(5, CELL_WORDS);
        cell_in_valid <= 1'b0;
        i_cpu.reg_write(OFS_MEM_CTRL, 8'h17);
        check(32'(insert_soc), 32'h0000_0001);
        for (int w = 0; w < CELL_WORDS; w++) begin
            if (w == 1) begin
                i_cpu.reg_write(OFS_MEM_CTRL, CTRL_RESET);
            end
            for (int b = 0; b < WORD_BYTES; b++) begin
                i_cpu.reg_write(8'(OFS_DATA_B3 + b), 8'hA5);
            end
        end
        check(32'(insert_soc), 32'h0000_0000);
        read_cell(5, CELL_WORDS);
        rd(OFS_DATA_B3, 8'h00);
        $display("test insert done");
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_irq();
        t_fill();
        t_flush();
        t_insert();
        finish_test();
    end
    // The tests need about two and a half thousand cycles; this cuts a hang short.
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule
`default_nettype wire
